// *** ftm_mode_ctrl.sv ***
`timescale 1ns/10ps
// Overview of operation
// [R1] power-up holds shutdown until valid pulse
// [R2] short high pulse enters active mode
// [R3] flash request rising edge enters flash
// [R4] flash current is flash scale times duty
// [R5] high pulse over 5 ms requests torch
// [R6] long pulse fall clears current control
// [R7] torch current is torch scale times duty
// [R8] flash timeout turns flash current off
// [R9] flash at 100C reduces sink currents
// [R10] thermal shutdown at 143C, 30C hysteresis
// [R11] torch exits after 5 ms low
// [R12] host holds pwm high at least 5 us
// [R13] flash only while flash request high
// [R14] flash request low, 5 ms low: shutdown
// [R15] host pwm frequency above 15 kHz
// [R16] timeout latches until request re-armed
// [R17] duty is high time over period
module ftm_mode_ctrl #(
   parameter int unsigned TORCH_ENTRY_CYC   = ftm_pkg::TORCH_ENTRY_CYC,
   parameter int unsigned SHUTDOWN_CYC      = ftm_pkg::SHUTDOWN_DELAY_CYC,
   parameter int unsigned FLASH_TIMEOUT_CYC = ftm_pkg::FLASH_TIMEOUT_CYC,
   parameter int unsigned DUTY_W            = ftm_pkg::DUTY_W,
   parameter int unsigned FS_W              = ftm_pkg::FS_W,
   parameter int unsigned TEMP_W            = ftm_pkg::TEMP_W
) (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                arst_n,
   // host pins (asynchronous)
   input  wire logic                flash_request_pin,
   input  wire logic                dim_torch_pin,
   // full-scale settings and die temperature
   input  wire logic [FS_W-1:0]     flash_full_scale,
   input  wire logic [FS_W-1:0]     torch_full_scale,
   input  wire logic [TEMP_W-1:0]   die_temp,
   // sink current commands and status
   output logic [FS_W-1:0]          sink_channel_a,
   output logic [FS_W-1:0]          sink_channel_b,
   output ftm_pkg::ftm_mode_t       mode,
   output logic                     flash_timed_out,
   output logic                     thermal_shutdown
);
   localparam int CW = 32;

   // two-flop synchronisers for both pins
   logic [1:0] sync_flash;
   logic [1:0] sync_dim;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sync_flash <= 2'h0;
         sync_dim   <= 2'h0;
      end else begin
         sync_flash <= {sync_flash[0], flash_request_pin};
         sync_dim   <= {sync_dim[0], dim_torch_pin};
      end
   end
   wire logic fr = sync_flash[1];
   wire logic dm = sync_dim[1];

   // pin history, counters, duty measurement, mode
   logic                 fr_d, dm_d;
   logic [CW-1:0]        high_cnt, low_cnt, per_cnt, hi_acc, flash_cnt;
   logic [DUTY_W-1:0]    duty;
   ftm_pkg::ftm_mode_t   next_mode;
   logic                 next_fr_d, next_dm_d, next_timed_out, next_tsd;
   logic [CW-1:0]        next_high_cnt, next_low_cnt, next_per_cnt, next_hi_acc, next_flash_cnt;
   logic [DUTY_W-1:0]    next_duty;
   logic [FS_W-1:0]      next_sink;
   logic [FS_W+DUTY_W-1:0] prod;

   wire logic fr_rise  = fr & ~fr_d;
   wire logic dm_rise  = dm & ~dm_d;
   wire logic dm_fall  = ~dm & dm_d;
   wire logic long_hi  = dm_fall && (high_cnt >= CW'(TORCH_ENTRY_CYC));
   wire logic long_lo  = ~dm && (low_cnt >= CW'(SHUTDOWN_CYC));

   // next-state computation
   always_comb begin
      next_fr_d      = fr;
      next_dm_d      = dm;
      next_mode      = mode;
      next_timed_out = flash_timed_out;
      next_tsd       = thermal_shutdown;
      next_high_cnt  = dm ? ((dm_rise) ? CW'(1) : high_cnt + CW'(1)) : high_cnt;
      next_low_cnt   = dm ? '0 : ((low_cnt == '1) ? low_cnt : low_cnt + CW'(1));
      next_per_cnt   = per_cnt + CW'(1);
      next_hi_acc    = dm ? hi_acc + CW'(1) : hi_acc;
      next_duty      = duty;
      next_flash_cnt = flash_cnt;
      prod           = '0;
      next_sink      = '0;
      // duty update once per period at each rising edge
      if (dm_rise) begin // see [R17]
         if (per_cnt != '0)
            next_duty = DUTY_W'(((hi_acc << DUTY_W) - hi_acc) / per_cnt);
         next_per_cnt = CW'(1);
         next_hi_acc  = CW'(1);
      end
      // long pulse fall resets current control; torch entry
      if (long_hi && !fr) begin // see [R5] see [R6]
         next_duty  = '0;
         // restart the period measurement so the long pulse never leaks into the first duty
         next_per_cnt = '0;
         next_hi_acc  = '0;
         next_mode  = ftm_pkg::FTM_TORCH;
      end else if (dm_fall && mode == ftm_pkg::FTM_SHUTDOWN) begin
         next_mode  = ftm_pkg::FTM_ACTIVE; // see [R1] see [R2]
      end
      // flash request only acts while high
      if (fr_rise && mode != ftm_pkg::FTM_SHUTDOWN) begin // see [R3]
         next_mode      = ftm_pkg::FTM_FLASH;
         next_flash_cnt = '0; // see [R16]
         next_timed_out = 1'b0;
      end else if (!fr && mode == ftm_pkg::FTM_FLASH) begin
         next_mode = ftm_pkg::FTM_ACTIVE; // see [R13]
      end
      if (mode == ftm_pkg::FTM_FLASH && !flash_timed_out) begin
         next_flash_cnt = flash_cnt + CW'(1);
         if (flash_cnt + CW'(1) >= CW'(FLASH_TIMEOUT_CYC))
            next_timed_out = 1'b1; // see [R8] see [R16]
      end
      // low for the shutdown delay with flash request low
      if (!fr && long_lo && mode != ftm_pkg::FTM_SHUTDOWN) begin // see [R11] see [R14]
         next_mode = ftm_pkg::FTM_SHUTDOWN;
         next_duty = '0;
      end
      // thermal shutdown with hysteresis
      if (die_temp >= TEMP_W'(ftm_pkg::THERM_SD_C))
         next_tsd = 1'b1; // see [R10]
      else if (die_temp <= TEMP_W'(ftm_pkg::THERM_SD_C - ftm_pkg::THERM_HYS_C))
         next_tsd = 1'b0; // see [R10]
      // current scaling
      if (mode == ftm_pkg::FTM_FLASH && !flash_timed_out)
         prod = flash_full_scale * duty; // see [R4]
      else if (mode == ftm_pkg::FTM_TORCH)
         prod = torch_full_scale * duty; // see [R7]
      next_sink = prod[FS_W+DUTY_W-1:DUTY_W];
      // thermal regulation halves flash current at 100C; trades light for staying out of shutdown
      if (mode == ftm_pkg::FTM_FLASH && die_temp >= TEMP_W'(ftm_pkg::THERM_REG_C))
         next_sink = next_sink >> ftm_pkg::THERM_SHIFT; // see [R9]
      if (thermal_shutdown)
         next_sink = '0;
   end

   // registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fr_d             <= 1'b0;
         dm_d             <= 1'b0;
         mode             <= ftm_pkg::FTM_SHUTDOWN; // see [R1]
         flash_timed_out  <= 1'b0;
         thermal_shutdown <= 1'b0;
         high_cnt         <= '0;
         low_cnt          <= '0;
         per_cnt          <= '0;
         hi_acc           <= '0;
         duty             <= '0;
         flash_cnt        <= '0;
         sink_channel_a   <= '0;
         sink_channel_b   <= '0;
      end else begin
         fr_d             <= next_fr_d;
         dm_d             <= next_dm_d;
         mode             <= next_mode;
         flash_timed_out  <= next_timed_out;
         thermal_shutdown <= next_tsd;
         high_cnt         <= next_high_cnt;
         low_cnt          <= next_low_cnt;
         per_cnt          <= next_per_cnt;
         hi_acc           <= next_hi_acc;
         duty             <= next_duty;
         flash_cnt        <= next_flash_cnt;
         sink_channel_a   <= next_sink;
         sink_channel_b   <= next_sink;
      end
   end

   // checks
   property p_reset_shutdown;
      @(posedge clk_sys) disable iff (!arst_n)
      (mode == ftm_pkg::FTM_SHUTDOWN && !dm_fall && !fr_rise) |=> mode != ftm_pkg::FTM_TORCH;
   endproperty
   a_reset_shutdown: assert property (p_reset_shutdown) else $error("left shutdown without pulse"); // see [R1]

   property p_flash_entry;
      @(posedge clk_sys) disable iff (!arst_n)
      (fr_rise && mode != ftm_pkg::FTM_SHUTDOWN && !long_lo) |=> mode == ftm_pkg::FTM_FLASH;
   endproperty
   a_flash_entry: assert property (p_flash_entry) else $error("flash not entered"); // see [R3]

   property p_flash_only_high;
      @(posedge clk_sys) disable iff (!arst_n)
      mode == ftm_pkg::FTM_FLASH |-> $past(fr);
   endproperty
   a_flash_only_high: assert property (p_flash_only_high) else $error("flash without request"); // see [R13]

   property p_timeout_off;
      @(posedge clk_sys) disable iff (!arst_n)
      flash_timed_out && mode == ftm_pkg::FTM_FLASH |=> sink_channel_a == '0;
   endproperty
   a_timeout_off: assert property (p_timeout_off) else $error("flash current after timeout"); // see [R8]

   property p_tsd_zero;
      @(posedge clk_sys) disable iff (!arst_n)
      thermal_shutdown |=> sink_channel_a == '0 && sink_channel_b == '0;
   endproperty
   a_tsd_zero: assert property (p_tsd_zero) else $error("current in thermal shutdown"); // see [R10]

   property p_torch_entry;
      @(posedge clk_sys) disable iff (!arst_n)
      (long_hi && !fr && !fr_rise) |=> mode == ftm_pkg::FTM_TORCH && duty == '0;
   endproperty
   a_torch_entry: assert property (p_torch_entry) else $error("torch not entered"); // see [R5]

   property p_shutdown_delay;
      @(posedge clk_sys) disable iff (!arst_n)
      ($past(mode) != ftm_pkg::FTM_SHUTDOWN && mode == ftm_pkg::FTM_SHUTDOWN) |-> $past(low_cnt) >= CW'(SHUTDOWN_CYC);
   endproperty
   a_shutdown_delay: assert property (p_shutdown_delay) else $error("early shutdown"); // see [R11]

   property p_match;
      @(posedge clk_sys) disable iff (!arst_n)
      sink_channel_a == sink_channel_b;
   endproperty
   a_match: assert property (p_match) else $error("sinks differ"); // see [R4]

   // a new flash request restarts the timer from zero with the timeout flag cleared
   sequence s_rearm;
      fr_rise && mode != ftm_pkg::FTM_SHUTDOWN;
   endsequence
   sequence s_timer_clear;
      !flash_timed_out && flash_cnt == '0;
   endsequence
   property p_rearm_clears;
      @(posedge clk_sys) disable iff (!arst_n)
      s_rearm |=> s_timer_clear;
   endproperty
   a_rearm_clears: assert property (p_rearm_clears) else $error("flash timer not restarted"); // see [R16]
endmodule : ftm_mode_ctrl

// *** ftm_pkg.sv ***
package ftm_pkg;
   // timebase
   localparam int unsigned CLK_HZ              = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS       = 100;
   // torch entry / shutdown delays, least times in ms
   localparam int unsigned TORCH_ENTRY_MS      = 5;
   localparam int unsigned SHUTDOWN_DELAY_MS   = 5;
   localparam int unsigned TORCH_ENTRY_CYC     = (TORCH_ENTRY_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SHUTDOWN_DELAY_CYC  = (SHUTDOWN_DELAY_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // flash timeout, nominal ms
   localparam int unsigned FLASH_TIMEOUT_MS    = 670;
   localparam int unsigned FLASH_TIMEOUT_CYC   = (FLASH_TIMEOUT_MS * 10_000) / (CLK_PERIOD_NS / 100) / 10 * 10;
   // minimum pwm high time, us
   localparam int unsigned PWM_MIN_HIGH_US     = 5;
   localparam int unsigned PWM_MIN_HIGH_CYC    = (PWM_MIN_HIGH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // thermal thresholds, degrees C
   localparam int unsigned THERM_REG_C         = 100;
   localparam int unsigned THERM_SD_C          = 143;
   localparam int unsigned THERM_HYS_C         = 30;
   // duty / scale / temperature widths, thermal shift
   localparam int unsigned DUTY_W              = 8;
   localparam int unsigned FS_W                = 10;
   localparam int unsigned TEMP_W              = 8;
   localparam int unsigned THERM_SHIFT         = 1;
   // modes
   typedef enum logic [1:0] {
      FTM_SHUTDOWN,
      FTM_ACTIVE,
      FTM_FLASH,
      FTM_TORCH
   } ftm_mode_t;
endpackage : ftm_pkg

// *** ftm_host_model.sv ***
`timescale 1ns/10ps
// host side of the pins: drives the flash request and pwm lines off the falling edge
module ftm_host_model (
   // clock
   input  wire logic clk_sys,
   // host pins, push-pull, so no released level to model
   output logic      flash_request_pin,
   output logic      dim_torch_pin
);
   // pins start low, as the pull-downs would leave them
   initial begin
      flash_request_pin = 1'b0;
      dim_torch_pin     = 1'b0;
   end
   // one pwm period; high time scaled with the shortened counts, period well above 15 kHz
   task automatic pwm(input int hi, input int lo);
      dim_torch_pin = 1'b1;
      repeat (hi) @(negedge clk_sys);
      dim_torch_pin = 1'b0;
      repeat (lo) @(negedge clk_sys);
   endtask : pwm
   // flash request level, held at least one cycle
   task automatic flash(input logic lvl);
      flash_request_pin = lvl;
      @(negedge clk_sys);
   endtask : flash
endmodule : ftm_host_model

// *** tb_flash_torch_mode_control.sv ***
`timescale 1ns/10ps
module tb_flash_torch_mode_control;
   // shortened counts keep the run small
   localparam int unsigned TE = 50;
   localparam int unsigned SD = 50;
   localparam int unsigned TO = 200;
   logic                         clk_sys;
   logic                         arst_n;
   logic                         flash_request_pin;
   logic                         dim_torch_pin;
   logic [ftm_pkg::FS_W-1:0]     flash_full_scale;
   logic [ftm_pkg::FS_W-1:0]     torch_full_scale;
   logic [ftm_pkg::TEMP_W-1:0]   die_temp;
   logic [ftm_pkg::FS_W-1:0]     sink_channel_a;
   logic [ftm_pkg::FS_W-1:0]     sink_channel_b;
   ftm_pkg::ftm_mode_t           mode;
   logic                         flash_timed_out;
   logic                         thermal_shutdown;
   int                           n_mismatch = 0;
   int                           checks = 0;
   // 10 MHz
   always #50 clk_sys = ~clk_sys;
   ftm_host_model host (.clk_sys(clk_sys), .flash_request_pin(flash_request_pin), .dim_torch_pin(dim_torch_pin));
   ftm_mode_ctrl #(.TORCH_ENTRY_CYC(TE), .SHUTDOWN_CYC(SD), .FLASH_TIMEOUT_CYC(TO)) dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .flash_request_pin(flash_request_pin), .dim_torch_pin(dim_torch_pin),
      .flash_full_scale(flash_full_scale), .torch_full_scale(torch_full_scale), .die_temp(die_temp),
      .sink_channel_a(sink_channel_a), .sink_channel_b(sink_channel_b), .mode(mode),
      .flash_timed_out(flash_timed_out), .thermal_shutdown(thermal_shutdown));
   // verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic cmp_mode(input ftm_pkg::ftm_mode_t exp);
      checks++;
      if (mode !== exp) begin
         n_mismatch++;
         $display("Error at %0t: mode %h expected %h", $time, mode, exp);
      end
   endtask : cmp_mode
   task automatic cmp_val(input logic [ftm_pkg::FS_W-1:0] got, input logic [ftm_pkg::FS_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : cmp_val
   // bounded wait for a mode; a spent bound ends the run
   task automatic wait_mode(input ftm_pkg::ftm_mode_t exp, input int bound);
      for (int i = 0; i < bound; i++) begin
         if (mode === exp) return;
         @(negedge clk_sys);
      end
      n_mismatch++;
      $display("Error at %0t: mode %h expected %h", $time, mode, exp);
      complete_run();
   endtask : wait_mode
   // flash request before any dim pulse must be ignored
   task automatic t_powerup;
      cmp_mode(ftm_pkg::FTM_SHUTDOWN);
      host.flash(1'b1);
      repeat (8) @(negedge clk_sys);
      cmp_mode(ftm_pkg::FTM_SHUTDOWN);
      host.flash(1'b0);
      repeat (4) @(negedge clk_sys);
   endtask : t_powerup
   // short pulses: duty 10/20 gives 10*255/20 = 127
   task automatic t_active;
      repeat (4) host.pwm(10, 10);
      cmp_mode(ftm_pkg::FTM_ACTIVE);
   endtask : t_active
   // flash current 512*127>>8 = 254, halved when hot, gone when request drops
   task automatic t_flash;
      host.flash(1'b1);
      repeat (3) host.pwm(10, 10);
      cmp_mode(ftm_pkg::FTM_FLASH);
      cmp_val(sink_channel_a, 10'h0fe);
      cmp_val(sink_channel_b, 10'h0fe);
      die_temp = 8'h64;
      repeat (2) host.pwm(10, 10);
      cmp_val(sink_channel_a, 10'h07f);
      die_temp = 8'h19;
      host.flash(1'b0);
      host.pwm(10, 10);
      cmp_mode(ftm_pkg::FTM_ACTIVE);
   endtask : t_flash
   // timer runs out after 200 cycles and stays off until a new rise; re-armed at full scale 1023*127>>8 = 507
   task automatic t_timeout;
      host.flash(1'b1);
      repeat (12) host.pwm(10, 10);
      cmp_val(sink_channel_a, 10'h000);
      cmp_val({9'h000, flash_timed_out}, 10'h001);
      host.flash(1'b0);
      host.pwm(10, 10);
      flash_full_scale = 10'h3ff;
      host.flash(1'b1);
      repeat (2) host.pwm(10, 10);
      cmp_val({9'h000, flash_timed_out}, 10'h000);
      cmp_val(sink_channel_a, 10'h1fb);
      host.flash(1'b0);
      host.pwm(10, 10);
   endtask : t_timeout
   // long pulse then pwm: first period carries no duty yet, then 256*127>>8 = 127, then 1023*127>>8 = 507
   task automatic t_torch;
      host.pwm(TE + 10, 10);
      host.pwm(10, 10);
      cmp_val(sink_channel_b, 10'h000);
      repeat (2) host.pwm(10, 10);
      cmp_mode(ftm_pkg::FTM_TORCH);
      cmp_val(sink_channel_b, 10'h07f);
      torch_full_scale = 10'h3ff;
      host.pwm(10, 10);
      cmp_val(sink_channel_a, 10'h1fb);
   endtask : t_torch
   // low for 40 cycles keeps torch; past 50 it shuts down
   task automatic t_shutdown;
      repeat (30) @(negedge clk_sys);
      cmp_mode(ftm_pkg::FTM_TORCH);
      wait_mode(ftm_pkg::FTM_SHUTDOWN, 40);
      cmp_mode(ftm_pkg::FTM_SHUTDOWN);
   endtask : t_shutdown
   // trip at 143, hold through 114, recover at 113
   task automatic t_thermal;
      logic [7:0] temps [4];
      logic [9:0] exps [4];
      temps = '{8'h8e, 8'h8f, 8'h72, 8'h71};
      exps  = '{10'h000, 10'h001, 10'h001, 10'h000};
      for (int i = 0; i < 4; i++) begin
         die_temp = temps[i];
         repeat (6) @(negedge clk_sys);
         cmp_val({9'h000, thermal_shutdown}, exps[i]);
      end
   endtask : t_thermal
   // mid-run reset from active: back to shutdown, flash ignored until a short pulse again
   task automatic t_reset;
      repeat (2) host.pwm(10, 10);
      cmp_mode(ftm_pkg::FTM_ACTIVE);
      arst_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      cmp_mode(ftm_pkg::FTM_SHUTDOWN);
      arst_n = 1'b1;
      @(negedge clk_sys);
      host.flash(1'b1);
      repeat (4) @(negedge clk_sys);
      cmp_mode(ftm_pkg::FTM_SHUTDOWN);
      host.flash(1'b0);
      host.pwm(10, 10);
      cmp_mode(ftm_pkg::FTM_ACTIVE);
   endtask : t_reset
   // main sequence
   initial begin
      clk_sys          = 1'b0;
      arst_n           = 1'b0;
      flash_full_scale = 10'h200;
      torch_full_scale = 10'h100;
      die_temp         = 8'h19;
      repeat (5) @(negedge clk_sys);
      arst_n = 1'b1;
      @(negedge clk_sys);
      t_powerup();
      t_active();
      t_flash();
      t_timeout();
      t_torch();
      t_shutdown();
      t_thermal();
      t_reset();
      complete_run();
   end
endmodule : tb_flash_torch_mode_control
